/* File: src/tslr_logger.sv */
/*
 Capture engine and APB register file of the four-lane triggered sample logger.
 Assumes base_tick is a one-cycle pulse per control interrupt, and that lane_vals
 and arm_val carry the quantities named by lane_sel and arm_src_num, with
 arm_kind giving the width of the trigger source.
*/
`include "tslr_map.svh"

// How it works
// RQ1: Readout adds bias, then multiplies by gain.
// RQ2: Round to nearest signed byte per lane.
// RQ3: Each lane burst is 500 bytes long.
// RQ4: Burst starts at index relative to trigger; here index 0 is the record start, pre_eff samples before the trigger.
// RQ5: Host stops, then waits for initialized status.
// RQ6: Single-shot arming enters waiting status.
// RQ7: Trigger crossing moves waiting to sampling.
// RQ8: Host reads data only when ready.
// RQ9: Per-lane enable, 0x00 off, 0x01 on.
// RQ10: Each lane samples its selected quantity.
// RQ11: Samples per lane from capture length.
// RQ12: Divider one samples every base interrupt.
// RQ13: Coupling 0x01 compares raw source value.
// RQ14: Slope 0x01 fires on rising crossing.
// RQ15: Threshold register matches source width.
// RQ16: Zero pretrigger stores from trigger onward.
// RQ17: Mode codes free, normal, single, stopped.
// RQ18: Single goes ready; others after stop.
// RQ19: Successive reads give successive burst bytes.
// RQ20: Capture length clamped to 500..8000.
module tslr_logger
   import tslr_pkg::*;
(
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic [15:0]     paddr,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire logic            base_tick,
   input  wire tslr_lane_vals_s lane_vals,
   input  wire logic [31:0]     arm_val,
   input  wire tslr_kind_e      arm_kind,
   output tslr_lane_sel_s       lane_sel,
   output logic [15:0]          arm_src_num
);
   logic [15:0]     div_r, len_r, asrc_r, pre_r, start_r, tick_r;
   logic [7:0]      mode_r, coup_r, edge_r, thr8_r;
   logic [15:0]     thr16_r;
   logic [23:0]     thr24_r;
   logic [31:0]     thr32_r, thrf_r, gain_r, bias_r, prev_r;
   logic [63:0]     thrd_r;
   logic [3:0]      ena_r, cena_r;
   tslr_lane_sel_s  sel_r;
   tslr_state_e     st_r;
   tslr_idx_t       wptr_r, fill_r, post_r, tpos_r, dpos_r, base_r;
   logic            pend_r, rec_r, was_rdy_r, go_r, nbusy_r;
   logic signed [17:0] nacc_r;
   logic [3:0][8:0] cnt_r;
   logic [31:0]     prdata_r;
   logic            pready_r, pslverr_r;

   logic            acc, done, wr, rd, busy, mapped, smp, hit, rise, fall, lane_rd;
   logic [11:0]     ridx;
   logic [1:0]      rlane;
   logic [31:0]     rmux, cur, lvl, sdata;
   logic [15:0]     div_eff, len_in;
   logic [13:0]     rsum;
   tslr_idx_t       len13, pre_eff, raddr, wnext;
   logic [7:0]      scaled, sbyte;

   function automatic logic at(input logic [15:0] a, input logic [11:0] i);
      return a == {2'b00, i, 2'b00};
   endfunction

   function automatic logic [31:0] sext(input tslr_kind_e k, input logic [31:0] v);
      unique case (k)
         KIND_BYTE:   sext = {{24{v[7]}}, v[7:0]};
         KIND_HALF:   sext = {{16{v[15]}}, v[15:0]};
         KIND_TRIPLE: sext = {{8{v[23]}}, v[23:0]};
         KIND_WORD:   sext = v;
      endcase
   endfunction

   assign acc = psel & penable;
   assign done = acc & pready_r;
   assign wr = done & pwrite;
   assign rd = done & ~pwrite;
   assign ridx = paddr[13:2];
   assign busy = go_r | nbusy_r;
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign lane_sel = sel_r;                                                // [RQ10]
   assign arm_src_num = asrc_r;

   // Signed capture length, clamped to what the store holds
   always_comb
   begin
      len_in = pwdata[15:0];
      if (pwdata[15] || pwdata[15:0] < `TSLR_LEN_MIN)
         len_in = `TSLR_LEN_MIN;                                           // [RQ20]
      else if (pwdata[15:0] > `TSLR_LEN_MAX)
         len_in = `TSLR_LEN_MAX;                                           // [RQ20]
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         div_r <= `TSLR_RST_DIV;
         len_r <= `TSLR_RST_LEN;
         ena_r <= 4'h0;
         sel_r <= {4{`TSLR_RST_SEL}};
         mode_r <= `TSLR_RST_MODE;
         asrc_r <= `TSLR_RST_SEL;
         coup_r <= `TSLR_RST_COUP;
         edge_r <= `TSLR_RST_EDGE;
         thr8_r <= 8'h00;
         thr16_r <= 16'h0000;
         thr24_r <= 24'h00_0000;
         thr32_r <= 32'h0000_0000;
         thrf_r <= 32'h0000_0000;
         thrd_r <= 64'h0000_0000_0000_0000;
         pre_r <= 16'h0000;
         gain_r <= 32'h0000_0000;
         bias_r <= 32'h0000_0000;
         start_r <= 16'h0000;
      end
      else if (wr)
      begin
         if (at(paddr, `TSLR_IDX_DIV)) div_r <= pwdata[15:0];
         if (at(paddr, `TSLR_IDX_LEN)) len_r <= len_in;                    // [RQ11]
         if (at(paddr, `TSLR_IDX_ENA))
            for (int l = 0; l < 4; l++)
               ena_r[l] <= pwdata[8*l];                                    // [RQ9]
         if (at(paddr, `TSLR_IDX_SEL01)) sel_r.num[1:0] <= pwdata;
         if (at(paddr, `TSLR_IDX_SEL23)) sel_r.num[3:2] <= pwdata;
         if (at(paddr, `TSLR_IDX_MODE) && pwdata[7:0] <= `TSLR_MODE_STOP) mode_r <= pwdata[7:0];
         if (at(paddr, `TSLR_IDX_ASRC)) asrc_r <= pwdata[15:0];
         if (at(paddr, `TSLR_IDX_COUP) && pwdata[7:0] <= `TSLR_COUP_MASK) coup_r <= pwdata[7:0];
         if (at(paddr, `TSLR_IDX_EDGE)) edge_r <= pwdata[7:0];
         if (at(paddr, `TSLR_IDX_THR8)) thr8_r <= pwdata[7:0];
         if (at(paddr, `TSLR_IDX_THR16)) thr16_r <= pwdata[15:0];
         if (at(paddr, `TSLR_IDX_THR24)) thr24_r <= pwdata[23:0];
         if (at(paddr, `TSLR_IDX_THR32)) thr32_r <= pwdata;
         if (at(paddr, `TSLR_IDX_THRF)) thrf_r <= pwdata;
         if (at(paddr, `TSLR_IDX_THRD_LO)) thrd_r[31:0] <= pwdata;
         if (at(paddr, `TSLR_IDX_THRD_HI)) thrd_r[63:32] <= pwdata;
         if (at(paddr, `TSLR_IDX_PRE)) pre_r <= pwdata[15:0];
         if (at(paddr, `TSLR_IDX_GAIN)) gain_r <= pwdata;
         if (at(paddr, `TSLR_IDX_BIAS)) bias_r <= pwdata;
         if (at(paddr, `TSLR_IDX_START)) start_r <= pwdata[15:0];
      end

   // Sample strobe from the base interrupt; zero behaves as one
   assign div_eff = (div_r == 16'h0000) ? 16'h0001 : div_r;
   assign smp = base_tick && (tick_r >= div_eff - 16'h0001);              // [RQ12]

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         tick_r <= 16'h0000;
      else if (base_tick)
         tick_r <= smp ? 16'h0000 : tick_r + 16'h0001;

   // Trigger source and level at the width of the selected source
   assign cur = sext(arm_kind, arm_val);
   always_comb
   begin
      unique case (arm_kind)
         KIND_BYTE:   lvl = sext(arm_kind, {24'h00_0000, thr8_r});         // [RQ15]
         KIND_HALF:   lvl = sext(arm_kind, {16'h0000, thr16_r});           // [RQ15]
         KIND_TRIPLE: lvl = sext(arm_kind, {8'h00, thr24_r});              // [RQ15]
         KIND_WORD:   lvl = thr32_r;                                       // [RQ15]
      endcase
      // AC coupling has no filter here and compares like DC
      if (coup_r == `TSLR_COUP_MASK)
      begin
         rise = |(~prev_r & cur & lvl);
         fall = |(prev_r & ~cur & lvl);
      end
      else
      begin
         rise = $signed(prev_r) < $signed(lvl) && $signed(cur) >= $signed(lvl);   // [RQ13]
         fall = $signed(prev_r) >= $signed(lvl) && $signed(cur) < $signed(lvl);
      end
      hit = (edge_r[0] && rise) || (edge_r[1] && fall);                    // [RQ14]
   end

   assign len13 = len_r[12:0];
   assign wnext = ({3'b000, wptr_r} + 16'h0001 == len_r) ? '0 : wptr_r + 13'h0001;
   // At least one slot stays after the trigger so a record always closes
   always_comb
   begin
      pre_eff = pre_r[12:0];
      if (pre_r[15])
         pre_eff = '0;
      else if (pre_r > len_r - 16'h0002)
         pre_eff = len13 - 13'h0002;
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         st_r <= ST_INIT;
         wptr_r <= '0;
         fill_r <= '0;
         post_r <= '0;
         tpos_r <= '0;
         dpos_r <= '0;
         prev_r <= 32'h0000_0000;
         pend_r <= 1'b0;
         rec_r <= 1'b0;
         cena_r <= 4'h0;
      end
      else if (wr && at(paddr, `TSLR_IDX_MODE))
      begin
         unique case (pwdata[7:0])
            `TSLR_MODE_FREE:
            begin
               st_r <= ST_SAMPLE;                                          // [RQ17]
               wptr_r <= '0;
               fill_r <= '0;
               tpos_r <= '0;
               post_r <= len13;
               pend_r <= 1'b0;
               rec_r <= 1'b0;
               cena_r <= ena_r;                                            // [RQ9]
            end
            `TSLR_MODE_NORMAL, `TSLR_MODE_SINGLE:
            begin
               st_r <= ST_WAIT;                                            // [RQ6]
               wptr_r <= '0;
               fill_r <= '0;
               pend_r <= 1'b0;
               rec_r <= 1'b0;
               cena_r <= ena_r;                                            // [RQ9]
            end
            `TSLR_MODE_STOP:
            begin
               if (st_r == ST_SAMPLE && mode_r != `TSLR_MODE_SINGLE)
                  pend_r <= 1'b1;                                          // [RQ18]
               else if (st_r == ST_WAIT && mode_r == `TSLR_MODE_NORMAL && rec_r)
                  st_r <= ST_READY;                                        // [RQ18]
               else
                  st_r <= ST_INIT;                                         // [RQ5]
            end
            default:
            begin
               st_r <= st_r;
            end
         endcase
      end
      else if (smp && (st_r == ST_WAIT || st_r == ST_SAMPLE))
      begin
         wptr_r <= wnext;
         prev_r <= cur;
         if (fill_r != len13)
            fill_r <= fill_r + 13'h0001;
         if (st_r == ST_WAIT)
         begin
            if (hit && fill_r != '0 && fill_r >= pre_eff)
            begin
               st_r <= ST_SAMPLE;                                          // [RQ7]
               // Record starts pre_eff slots before the trigger sample
               tpos_r <= (wptr_r >= pre_eff) ? wptr_r - pre_eff : wptr_r + len13 - pre_eff;   // [RQ16]
               post_r <= len13 - pre_eff - 13'h0001;                       // [RQ11]
            end
         end
         else if (post_r == 13'h0001)
         begin
            rec_r <= 1'b1;
            dpos_r <= tpos_r;
            if (pend_r || mode_r == `TSLR_MODE_SINGLE)
               st_r <= ST_READY;                                           // [RQ18]
            else if (mode_r == `TSLR_MODE_NORMAL)
               st_r <= ST_WAIT;                                            // [RQ17]
            else
            begin
               tpos_r <= wnext;
               post_r <= len13;
            end
         end
         else
            post_r <= post_r - 13'h0001;
      end

   // Read start normalised into the record one length step per cycle
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         was_rdy_r <= 1'b0;
         go_r <= 1'b0;
         nbusy_r <= 1'b0;
         nacc_r <= '0;
         base_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         was_rdy_r <= st_r == ST_READY;
         go_r <= (wr && at(paddr, `TSLR_IDX_START)) || (st_r == ST_READY && !was_rdy_r);
         if (go_r)
         begin
            nacc_r <= signed'({5'b00000, dpos_r}) + 18'(signed'(start_r)); // [RQ4]
            nbusy_r <= 1'b1;
            cnt_r <= '0;
         end
         else if (nbusy_r)
         begin
            if (nacc_r < 0)
               nacc_r <= nacc_r + signed'({5'b00000, len13});
            else if (nacc_r >= signed'({5'b00000, len13}))
               nacc_r <= nacc_r - signed'({5'b00000, len13});
            else
            begin
               base_r <= nacc_r[12:0];                                     // [RQ4]
               nbusy_r <= 1'b0;
            end
         end
         else if (rd && lane_rd && st_r == ST_READY)
            cnt_r[rlane] <= (cnt_r[rlane] == `TSLR_BURST - 9'h001) ? 9'h000 : cnt_r[rlane] + 9'h001;   // [RQ3] [RQ19]
      end

   assign rsum = {1'b0, base_r} + {5'b00000, cnt_r[rlane]};
   assign raddr = (rsum >= {1'b0, len13}) ? 13'(rsum - {1'b0, len13}) : rsum[12:0];

   tslr_sample_store u_store (
      .pclk   (pclk),
      .we     (smp && (st_r == ST_WAIT || st_r == ST_SAMPLE)),
      .widx   (wptr_r),
      .wlanes (cena_r),
      .wdata  (lane_vals),
      .ridx   (raddr),
      .rlane  (rlane),
      .rdata  (sdata)
   );

   tslr_scale u_scale (
      .sample (sdata),
      .bias   (bias_r),
      .gain   (gain_r),
      .result (scaled)
   );

   // Captured data only while ready, and only for captured lanes
   assign sbyte = (st_r == ST_READY && cena_r[rlane]) ? scaled : 8'h00;    // [RQ8] [RQ2]

   always_comb
   begin
      rmux = 32'h0000_0000;
      mapped = 1'b1;
      lane_rd = 1'b0;
      rlane = 2'(ridx - `TSLR_IDX_OUT0);
      if (paddr[15:14] != 2'b00 || paddr[1:0] != 2'b00)
         mapped = 1'b0;
      else
      begin
         unique case (ridx)
            `TSLR_IDX_DIV:     rmux = {16'h0000, div_r};
            `TSLR_IDX_RATE:    rmux = `TSLR_RST_RATE;
            `TSLR_IDX_LEN:     rmux = {16'h0000, len_r};
            `TSLR_IDX_ENA:     rmux = {7'h00, ena_r[3], 7'h00, ena_r[2], 7'h00, ena_r[1], 7'h00, ena_r[0]};
            `TSLR_IDX_SEL01:   rmux = sel_r.num[1:0];
            `TSLR_IDX_SEL23:   rmux = sel_r.num[3:2];
            `TSLR_IDX_MODE:    rmux = {24'h00_0000, mode_r};
            `TSLR_IDX_ASRC:    rmux = {16'h0000, asrc_r};
            `TSLR_IDX_COUP:    rmux = {24'h00_0000, coup_r};
            `TSLR_IDX_EDGE:    rmux = {24'h00_0000, edge_r};
            `TSLR_IDX_THR8:    rmux = {24'h00_0000, thr8_r};
            `TSLR_IDX_THR16:   rmux = {16'h0000, thr16_r};
            `TSLR_IDX_THR24:   rmux = {8'h00, thr24_r};
            `TSLR_IDX_THR32:   rmux = thr32_r;
            `TSLR_IDX_THRF:    rmux = thrf_r;
            `TSLR_IDX_THRD_LO: rmux = thrd_r[31:0];
            `TSLR_IDX_THRD_HI: rmux = thrd_r[63:32];
            `TSLR_IDX_PRE:     rmux = {16'h0000, pre_r};
            `TSLR_IDX_GAIN:    rmux = gain_r;
            `TSLR_IDX_BIAS:    rmux = bias_r;
            `TSLR_IDX_START:   rmux = {16'h0000, start_r};
            `TSLR_IDX_STATE:
            begin
               unique case (st_r)
                  ST_INIT:   rmux = {24'h00_0000, `TSLR_STAT_INIT};
                  ST_WAIT:   rmux = {24'h00_0000, `TSLR_STAT_WAIT};           // [RQ6]
                  ST_SAMPLE: rmux = {24'h00_0000, `TSLR_STAT_SAMPLE};         // [RQ7]
                  ST_READY:  rmux = {24'h00_0000, `TSLR_STAT_READY};
               endcase
            end
            `TSLR_IDX_OUT0, `TSLR_IDX_OUT1, `TSLR_IDX_OUT2, `TSLR_IDX_OUT3:
            begin
               rmux = {24'h00_0000, sbyte};                                // [RQ2]
               lane_rd = 1'b1;
            end
            default:
            begin
               mapped = 1'b0;
            end
         endcase
      end
   end

   // One wait state; held longer while the read start settles
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (pready_r)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else if (acc && !busy)
      begin
         pready_r <= 1'b1;
         prdata_r <= (mapped && !pwrite) ? rmux : 32'h0000_0000;
         pslverr_r <= !mapped;
      end
endmodule

/* File: src/tslr_map.svh */
/*
 Register indices, reset values, codes and limits of the triggered sample logger.
 Assumes inclusion by bare name; the byte address of a register is four times its index.
*/
`ifndef TSLR_MAP_SVH
`define TSLR_MAP_SVH
`define TSLR_IDX_DIV      12'h6d6
`define TSLR_IDX_RATE     12'h6d7
`define TSLR_IDX_LEN      12'h6d8
`define TSLR_IDX_ENA      12'h6d9
`define TSLR_IDX_SEL01    12'h6da
`define TSLR_IDX_MODE     12'h6db
`define TSLR_IDX_ASRC     12'h6dc
`define TSLR_IDX_COUP     12'h6dd
`define TSLR_IDX_EDGE     12'h6de
`define TSLR_IDX_THR8     12'h6df
`define TSLR_IDX_THR16    12'h6e0
`define TSLR_IDX_THR24    12'h6e1
`define TSLR_IDX_THR32    12'h6e2
`define TSLR_IDX_THRF     12'h6e3
`define TSLR_IDX_THRD_LO  12'h6e4
`define TSLR_IDX_PRE      12'h6e5
`define TSLR_IDX_THRD_HI  12'h6e6
`define TSLR_IDX_STATE    12'h6e7
`define TSLR_IDX_GAIN     12'h6e8
`define TSLR_IDX_BIAS     12'h6e9
`define TSLR_IDX_START    12'h6ea
`define TSLR_IDX_OUT0     12'h6eb
`define TSLR_IDX_OUT1     12'h6ec
`define TSLR_IDX_OUT2     12'h6ed
`define TSLR_IDX_OUT3     12'h6ee
`define TSLR_IDX_SEL23    12'h6ef
`define TSLR_RST_DIV      16'h0001
`define TSLR_RST_RATE     32'h0000_26c0
`define TSLR_RST_LEN      16'h01f4
`define TSLR_RST_SEL      16'h03e8
`define TSLR_RST_MODE     8'h03
`define TSLR_RST_COUP     8'h01
`define TSLR_RST_EDGE     8'h01
`define TSLR_LEN_MIN      16'h01f4
`define TSLR_LEN_MAX      16'h1f40
`define TSLR_BURST        9'h1f4
`define TSLR_MODE_FREE    8'h00
`define TSLR_MODE_NORMAL  8'h01
`define TSLR_MODE_SINGLE  8'h02
`define TSLR_MODE_STOP    8'h03
`define TSLR_STAT_INIT    8'h00
`define TSLR_STAT_WAIT    8'h01
`define TSLR_STAT_SAMPLE  8'h02
`define TSLR_STAT_READY   8'h03
`define TSLR_COUP_MASK    8'h02
`endif

/* File: src/tslr_pkg.sv */
/*
 Types shared by the sample logger modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tslr_pkg;
   typedef enum logic [1:0] {ST_INIT, ST_WAIT, ST_SAMPLE, ST_READY} tslr_state_e;
   typedef enum logic [1:0] {KIND_BYTE, KIND_HALF, KIND_TRIPLE, KIND_WORD} tslr_kind_e;
   typedef struct packed {
      logic [3:0][31:0] val;
   } tslr_lane_vals_s;
   typedef struct packed {
      logic [3:0][15:0] num;
   } tslr_lane_sel_s;
   typedef logic [12:0] tslr_idx_t;
endpackage

/* File: src/tslr_sample_store.sv */
/*
 Flip-flop sample store, one bank of 8000 words (the maximum capture length) per lane.
 Assumes indices below the maximum capture length; contents have no reset.
*/
`include "tslr_map.svh"

module tslr_sample_store
   import tslr_pkg::*;
(
   input  wire logic            pclk,
   input  wire logic            we,
   input  wire tslr_idx_t       widx,
   input  wire logic [3:0]      wlanes,
   input  wire tslr_lane_vals_s wdata,
   input  wire tslr_idx_t       ridx,
   input  wire logic [1:0]      rlane,
   output logic [31:0]          rdata
);
   logic [3:0][31:0] rd_lane;

   for (genvar g = 0; g < 4; g++)
   begin : g_lane
      logic [31:0] mem [`TSLR_LEN_MAX];
      always_ff @(posedge pclk)
         if (we && wlanes[g])
            mem[widx] <= wdata.val[g];
      assign rd_lane[g] = mem[ridx];
   end

   assign rdata = rd_lane[rlane];
endmodule

/* File: src/tslr_scale.sv */
/*
 Combinational readout scaling: (sample + bias) * gain, rounded to a signed byte.
 Assumes bias and gain in single-precision format; denormals count as zero.
*/
module tslr_scale
(
   input  wire logic [31:0] sample,
   input  wire logic [31:0] bias,
   input  wire logic [31:0] gain,
   output logic [7:0]       result
);
   logic [7:0]         eb;
   logic [7:0]         eg;
   logic [23:0]        mb;
   logic [23:0]        mg;
   logic signed [55:0] bfx;
   logic signed [55:0] sum;
   logic [55:0]        mag;
   logic [79:0]        prod;
   logic [79:0]        r;
   logic [8:0]         sh;
   logic               neg;
   logic               sat;

   always_comb
   begin
      eb = bias[30:23];
      eg = gain[30:23];
      mb = (eb == 8'h00) ? 24'h00_0000 : {1'b1, bias[22:0]};
      mg = (eg == 8'h00) ? 24'h00_0000 : {1'b1, gain[22:0]};
      // Bias held with 16 fraction bits; very large biases wrap
      if (eb >= 8'h86)
         bfx = signed'({32'h0000_0000, mb} << (eb - 8'h86));
      else
         bfx = signed'({32'h0000_0000, mb} >> (8'h86 - eb));
      if (bias[31])
         bfx = -bfx;
      sum = signed'({{8{sample[31]}}, sample, 16'h0000}) + bfx;           // [RQ1]
      neg = sum[55] ^ gain[31];
      mag = sum[55] ? 56'(-sum) : 56'(sum);
      prod = {24'h00_0000, mag} * {56'h0, mg};                             // [RQ1]
      r = '0;
      sat = 1'b0;
      sh = 9'h000;
      if (eg > 8'ha6)
         sat = |prod;
      else if (eg == 8'ha6)
         r = prod;
      else
      begin
         sh = 9'h0a6 - {1'b0, eg};
         // Half away from zero via the last dropped bit
         if (sh < 9'h050)
            r = (prod >> sh) + ((prod >> (sh - 9'h001)) & 80'h1);         // [RQ2]
      end
      if (!neg)
         result = (sat || r > 80'h7f) ? 8'h7f : r[7:0];                   // [RQ2]
      else
         result = (sat || r > 80'h80) ? 8'h80 : 8'(8'h00 - r[7:0]);       // [RQ2]
   end
endmodule

/* File: testbench/tslr_logger_assertions.sv */
/* Checker on the logger's APB answer and select outputs.
 Bound to tslr_logger by name; sees its ports only. */
module tslr_logger_chk
   import tslr_pkg::*;
(
   input wire logic           pclk,
   input wire logic           presetn,
   input wire logic [15:0]    paddr,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   input wire tslr_lane_sel_s lane_sel,
   input wire logic [15:0]    arm_src_num
);
   logic rdv;
   assign rdv = pready && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
   a_answer_bound: assert property (psel && !penable |-> ##[2:100] pready) else $error("no answer");
   a_error_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error data");
   a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data");
   a_state_code: assert property (rdv && paddr == 16'h1b9c |-> prdata < 32'h4) else $error("state code");
   a_mode_code: assert property (rdv && paddr == 16'h1b6c |-> prdata < 32'h4) else $error("mode code");
   a_lane_byte: assert property (rdv && paddr == 16'h1bac |-> prdata[31:8] == 24'h0) else $error("lane");
   a_reset_select: assert property ($rose(presetn) |-> arm_src_num == 16'h03e8 && lane_sel == {4{16'h03e8}})
      else $error("select reset");
   c_refused: cover property (pslverr);
   c_lane_read: cover property (rdv && paddr == 16'h1bac);
   c_ready: cover property (rdv && paddr == 16'h1b9c && prdata == 32'h3);
endmodule
bind tslr_logger tslr_logger_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .lane_sel(lane_sel), .arm_src_num(arm_src_num));

/* File: testbench/tslr_logger_tb.sv */
/* Bench: defaults, refusals, one single-shot capture and its readout.
 Assumes the checker is compiled alongside. */
module tslr_logger_tb
   import tslr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic           pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic           base_tick = 1'b0, run = 1'b0, err, pready, pslverr;
   logic [1:0]     tcnt = 2'h0;
   logic [15:0]    paddr = 16'h0000, arm_src_num;
   logic [31:0]    pwdata = 32'h0000_0000, ramp = 32'hffff_fff5, rd, prdata;
   tslr_lane_sel_s lane_sel;
   int             num_errors = 0, total_checks = 0, cycles = 0;
   tslr_logger dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .base_tick(base_tick), .lane_vals({64'h0, 32'h0000_0040, ramp}), .arm_val(ramp),
      .arm_kind(KIND_WORD), .lane_sel(lane_sel), .arm_src_num(arm_src_num));
   initial
      forever #2.5 pclk = ~pclk;
   // Odd ramp values so the crossing lands on 1 whether the compare is > or >=
   always @(posedge pclk)
   begin
      tcnt <= tcnt + 2'h1;
      base_tick <= tcnt == 2'h3;
      cycles <= cycles + 1;
      if (base_tick && run)
         ramp <= ramp + 32'h0000_0002;
      if (cycles == 20000)
      begin
         num_errors++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_defaults();
      rc(12'h6d6, 32'h0000_0001);
      rc(12'h6d7, 32'h0000_26c0);
      rc(12'h6d8, 32'h0000_01f4);
      rc(12'h6d9, 32'h0000_0000);
      rc(12'h6da, 32'h03e8_03e8);
      rc(12'h6db, 32'h0000_0003);
      rc(12'h6dd, 32'h0000_0001);
      rc(12'h6de, 32'h0000_0001);
      rc(12'h6e7, 32'h0000_0000);
      $display("defaults done");
   endtask
   task automatic t_refuse();
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'b1, 12'h6d7, 32'h0000_1234);
      rc(12'h6d7, 32'h0000_26c0);
      apb(1'b1, 12'h6db, 32'h0000_0004);
      rc(12'h6db, 32'h0000_0003);
      apb(1'b1, 12'h6d8, 32'h0000_2000);
      rc(12'h6d8, 32'h0000_1f40);
      apb(1'b1, 12'h6d8, 32'h0000_0064);
      rc(12'h6d8, 32'h0000_01f4);
      apb(1'b1, 12'h6da, 32'h0456_0789);
      apb(1'b1, 12'h6dc, 32'h0000_0123);
      @(posedge pclk);
      chk({lane_sel.num[1], lane_sel.num[0]}, 32'h0456_0789);
      chk({16'h0, arm_src_num}, 32'h0000_0123);
      $display("refusals done");
   endtask
   task automatic t_capture();
      int   n = 0;
      logic saw = 1'b0;
      apb(1'b1, 12'h6db, 32'h0000_0000);
      rc(12'h6e7, 32'h0000_0002);
      apb(1'b1, 12'h6db, 32'h0000_0001);
      rc(12'h6e7, 32'h0000_0001);
      apb(1'b1, 12'h6db, 32'h0000_0003);
      rc(12'h6e7, 32'h0000_0000);
      apb(1'b1, 12'h6d9, 32'h0000_0001);
      apb(1'b1, 12'h6e2, 32'h0000_0000);
      apb(1'b1, 12'h6e5, 32'h0000_0000);
      apb(1'b1, 12'h6e8, 32'h3e80_0000);
      apb(1'b1, 12'h6e9, 32'h3f80_0000);
      apb(1'b1, 12'h6db, 32'h0000_0002);
      rc(12'h6e7, 32'h0000_0001);
      run <= 1'b1;
      do
      begin
         apb(1'b0, 12'h6e7, 32'h0000_0000);
         saw |= rd === 32'h0000_0002;
      end
      while (rd !== 32'h0000_0003 && ++n < 2000);
      chk({31'h0, saw}, 32'h0000_0001);
      chk(rd, 32'h0000_0003);
      $display("capture done");
   endtask
   // Sample k is 1+2k; (1+2k+1)*0.25 rounds to (k+2)/2, saturating at 127
   task automatic t_readout();
      int k;
      apb(1'b1, 12'h6ea, 32'h0000_0000);
      for (k = 0; k < 501; k++)
         rc(12'h6eb, k % 500 < 254 ? 32'((k % 500 + 2) / 2) : 32'h0000_007f);
      apb(1'b1, 12'h6ea, 32'h0000_0004);
      rc(12'h6eb, 32'h0000_0003);
      rc(12'h6ec, 32'h0000_0000);
      $display("readout done");
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_refuse();
      t_capture();
      t_readout();
      test_done();
   end
endmodule
